// >>> verilog/vic_controller.sv
// Purpose: vectored interrupt controller with flag, mask and save logic
// Assumes: event inputs are one-cycle pulses synchronous to clk
// Notes: arst_n covers power-on, reset pin and watchdog reset
module vic_controller (
  input wire logic clk,
  input wire logic arst_n,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // interrupt sources
  input wire logic ext_int_pin,
  input wire logic [7:0] port5_pins,
  input wire logic port5_read,
  input wire logic main_timer_ovf,
  input wire logic timer_a_ovf,
  input wire logic timer_b_ovf,
  input wire logic timer_c_ovf,
  input wire logic conversion_done,
  input wire logic comparator_change,
  input wire logic high_pulse_underflow,
  input wire logic low_pulse_underflow,
  // core side
  input wire logic enable_interrupts_instr,
  input wire logic disable_interrupts_instr,
  input wire logic return_from_interrupt_instr,
  input wire logic sleep_instr,
  input wire logic int_ack,
  input wire logic [7:0] accumulator_in,
  input wire logic [7:0] processor_status_in,
  input wire logic [7:0] bank_select_in,
  output logic int_request,
  output logic [vic_pkg::VEC_W-1:0] int_vector,
  output logic wake_up,
  output logic asleep,
  output logic restore_valid,
  output logic [7:0] accumulator_out,
  output logic [7:0] processor_status_out,
  output logic [7:0] bank_select_out
);
  import vic_pkg::*;

  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_SERVICE} vic_state_type;
  vic_state_type state;
  vic_state_type next_state;

  logic [7:0] primary_flag_reg;
  logic [7:0] secondary_flag_reg;
  logic [7:0] primary_mask_reg;
  logic [7:0] secondary_mask_reg;
  logic [7:0] control_register;
  logic [7:0] port5_ref;
  logic global_enable;
  logic wake_armed;
  logic ext_filtered_q;
  logic ext_filtered;
  logic ext_prev;

  // bus decode
  wire [REG_IDX_W-1:0] reg_idx = wb_adr_i[7:2];
  wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire bus_wr = bus_req && wb_we_i && wb_sel_i[0];
  wire wr_pri_status = bus_wr && (reg_idx == PRI_STATUS_IDX);
  wire wr_sec_status = bus_wr && (reg_idx == SEC_STATUS_IDX);
  wire wr_pri_mask = bus_wr && (reg_idx == PRI_MASK_IDX);
  wire wr_sec_mask = bus_wr && (reg_idx == SEC_MASK_IDX);
  wire wr_control = bus_wr && (reg_idx == CONTROL_IDX);
  wire [7:0] wdata = wb_dat_i[7:0];

  // external input path
  wire lxt_mode = control_register[CTL_LXT_BIT];
  wire ext_edge_select = control_register[CTL_EDGE_BIT];

  vic_noise_filter #(
    .LEN(NOISE_REJECT_CYCLES)
  ) u_filter (
    .clk(clk),
    .arst_n(arst_n),
    .din(ext_int_pin),
    .dout(ext_filtered_q)
  );

  assign ext_filtered = lxt_mode ? ext_int_pin : ext_filtered_q;
  // edge select 0 = rising, 1 = falling
  wire ext_rise = ext_filtered && !ext_prev;
  wire ext_fall = !ext_filtered && ext_prev;
  wire ext_event = ext_edge_select ? ext_fall : ext_rise;

  // pin-change detector against the last read reference
  wire pin_changed = |(port5_pins ^ port5_ref);
  // unlike the other flags, pin change only latches when its mask is set
  wire pin_event = pin_changed && primary_mask_reg[PRI_PIN_BIT];

  // hardware set terms
  logic [7:0] pri_set;
  always_comb begin
    pri_set = 8'h00;
    pri_set[PRI_MAIN_BIT] = main_timer_ovf;
    pri_set[PRI_PIN_BIT] = pin_event;
    pri_set[PRI_EXT_BIT] = ext_event;
    pri_set[PRI_TA_BIT] = timer_a_ovf;
    pri_set[PRI_TB_BIT] = timer_b_ovf;
    pri_set[PRI_TC_BIT] = timer_c_ovf;
    pri_set[PRI_HIGH_BIT] = high_pulse_underflow;
    pri_set[PRI_LOW_BIT] = low_pulse_underflow;
  end

  logic [7:0] sec_set;
  always_comb begin
    sec_set = 8'h00;
    sec_set[SEC_ADC_BIT] = conversion_done;
    sec_set[SEC_CMP_BIT] = comparator_change;
  end

  // set wins over a clearing write in the same cycle
  wire [7:0] next_pri_flags = (wr_pri_status ? wdata : primary_flag_reg) | pri_set;
  wire [7:0] next_sec_flags =
    ((wr_sec_status ? wdata : secondary_flag_reg) | sec_set) & SEC_RW_MASK;

  // pending, in priority order
  wire [7:0] pri_pending = primary_flag_reg & primary_mask_reg;
  wire [7:0] sec_pending = secondary_flag_reg & secondary_mask_reg;
  logic [NUM_SOURCES-1:0] pending;
  always_comb begin
    pending[0] = pri_pending[PRI_EXT_BIT];
    pending[1] = pri_pending[PRI_PIN_BIT];
    pending[2] = pri_pending[PRI_MAIN_BIT];
    pending[3] = sec_pending[SEC_ADC_BIT];
    pending[4] = sec_pending[SEC_CMP_BIT];
    pending[5] = pri_pending[PRI_HIGH_BIT];
    pending[6] = pri_pending[PRI_LOW_BIT];
    pending[7] = pri_pending[PRI_TA_BIT];
    pending[8] = pri_pending[PRI_TB_BIT];
    pending[9] = pri_pending[PRI_TC_BIT];
  end

  logic [VEC_W-1:0] chosen_vector;
  always_comb begin
    chosen_vector = VECTOR_TABLE[0];
    // scan from lowest so the highest pending wins
    for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
      if (pending[i]) begin
        chosen_vector = VECTOR_TABLE[i];
      end
    end
  end

  wire any_pending = |pending;
  wire accept = int_request && int_ack;

  // wake sources while asleep
  wire pin_wake = pin_changed && wake_armed;
  wire adc_wake = conversion_done && secondary_mask_reg[SEC_CONVERSION_WAKE_ENABLE_BIT] == 1'b0 &&
                  secondary_flag_reg[SEC_CONVERSION_WAKE_ENABLE_BIT];
  wire cmp_wake = comparator_change && secondary_flag_reg[SEC_COMPARATOR_WAKE_ENABLE_BIT];
  wire wake_now = (state == ST_SLEEP) && (pin_wake || adc_wake || cmp_wake);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (accept) begin
          next_state = ST_SERVICE;
        end else if (sleep_instr) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_now) begin
          next_state = ST_RUN;
        end
      end
      ST_SERVICE: begin
        if (return_from_interrupt_instr) begin
          next_state = ST_RUN;
        end else if (sleep_instr) begin
          next_state = ST_SLEEP;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // status and configuration registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      primary_flag_reg <= STATUS_RESET;
      secondary_flag_reg <= STATUS_RESET;
      primary_mask_reg <= MASK_RESET;
      secondary_mask_reg <= MASK_RESET;
      control_register <= CONTROL_RESET;
    end else begin
      primary_flag_reg <= next_pri_flags;
      secondary_flag_reg <= next_sec_flags;
      if (wr_pri_mask) begin
        primary_mask_reg <= wdata;
      end
      if (wr_sec_mask) begin
        secondary_mask_reg <= wdata;
      end
      if (wr_control) begin
        control_register <= wdata;
      end
    end
  end

  // port 5 reference and edge history
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port5_ref <= PORT5_REF_RESET;
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_filtered;
      if (port5_read) begin
        port5_ref <= port5_pins;
      end
    end
  end

  // global enable; accept beats a same-cycle enable instruction
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      global_enable <= 1'b0;
    end else if (accept || disable_interrupts_instr) begin
      global_enable <= 1'b0;
    end else if (enable_interrupts_instr || return_from_interrupt_instr) begin
      global_enable <= 1'b1;
    end
  end

  // the pin-change enable is frozen at the sleep instruction
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_armed <= 1'b0;
    end else if (sleep_instr && state != ST_SLEEP) begin
      wake_armed <= primary_mask_reg[PRI_PIN_BIT];
    end
  end

  // request toward the core; withdrawn the cycle after accept
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_request <= 1'b0;
      int_vector <= VECTOR_TABLE[0];
      wake_up <= 1'b0;
      asleep <= 1'b0;
      restore_valid <= 1'b0;
    end else begin
      // with enable off after wake the core just continues inline
      int_request <= global_enable && any_pending && !accept;
      int_vector <= chosen_vector;
      wake_up <= wake_now;
      asleep <= (next_state == ST_SLEEP);
      restore_valid <= return_from_interrupt_instr && state == ST_SERVICE;
    end
  end

  vic_save_area u_save (
    .clk(clk),
    .arst_n(arst_n),
    .save(accept),
    .accumulator_in(accumulator_in),
    .processor_status_in(processor_status_in),
    .bank_select_in(bank_select_in),
    .accumulator_out(accumulator_out),
    .processor_status_out(processor_status_out),
    .bank_select_out(bank_select_out)
  );

  // read mux
  logic [7:0] rdata;
  always_comb begin
    unique case (reg_idx)
      PRI_STATUS_IDX: rdata = primary_flag_reg & primary_mask_reg;
      SEC_STATUS_IDX: rdata = secondary_flag_reg & SEC_RW_MASK;
      PRI_MASK_IDX: rdata = primary_mask_reg;
      SEC_MASK_IDX: rdata = secondary_mask_reg;
      CONTROL_IDX: rdata = control_register;
      CORE_STATE_IDX: rdata = {5'h00, state == ST_SERVICE, state == ST_SLEEP, global_enable};
      default: rdata = 8'h00;
    endcase
  end

  // one wait state; unmapped indexes ack with zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? {24'h00_0000, rdata} : 32'h0000_0000;
    end
  end
endmodule // vic_controller

// >>> verilog/vic_pkg.sv
// Purpose: constants shared by the vectored interrupt controller
// Assumes: byte address on the bus is four times the register index
// Notes: status registers sit at indexes 0x0e and 0x0f
package vic_pkg;
  localparam int REG_IDX_W = 6;
  localparam logic [5:0] SEC_STATUS_IDX = 6'h0e;
  localparam logic [5:0] PRI_STATUS_IDX = 6'h0f;
  localparam logic [5:0] PRI_MASK_IDX = 6'h10;
  localparam logic [5:0] SEC_MASK_IDX = 6'h11;
  localparam logic [5:0] CONTROL_IDX = 6'h12;
  localparam logic [5:0] CORE_STATE_IDX = 6'h13;

  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] PORT5_REF_RESET = 8'hff;

  // primary flag positions
  localparam int PRI_MAIN_BIT = 0;
  localparam int PRI_PIN_BIT = 1;
  localparam int PRI_EXT_BIT = 2;
  localparam int PRI_TA_BIT = 3;
  localparam int PRI_TB_BIT = 4;
  localparam int PRI_TC_BIT = 5;
  localparam int PRI_HIGH_BIT = 6;
  localparam int PRI_LOW_BIT = 7;
  // secondary positions
  localparam int SEC_INPUT_CHANGE_WAKE_ENABLE_BIT = 1;
  localparam int SEC_COMPARATOR_WAKE_ENABLE_BIT = 2;
  localparam int SEC_CONVERSION_WAKE_ENABLE_BIT = 3;
  localparam int SEC_CMP_BIT = 4;
  localparam int SEC_ADC_BIT = 5;
  localparam logic [7:0] SEC_RW_MASK = 8'h3e;
  // control positions
  localparam int CTL_EDGE_BIT = 0;
  localparam int CTL_LXT_BIT = 1;

  localparam int NOISE_REJECT_CYCLES = 8;
  localparam int NUM_SOURCES = 10;
  localparam int VEC_W = 10;
  // indexed by priority, 0 is highest
  localparam logic [9:0] VECTOR_TABLE [0:9] = '{
    10'h003, 10'h006, 10'h009, 10'h00c, 10'h00f,
    10'h012, 10'h015, 10'h018, 10'h01b, 10'h01e
  };
endpackage

// >>> verilog/vic_noise_filter.sv
// Purpose: digital noise rejection for the external interrupt input
// Assumes: input synchronous to clk
// Notes: output follows input only after it held a new level LEN clocks
module vic_noise_filter #(
  parameter int LEN = vic_pkg::NOISE_REJECT_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic din,
  output logic dout
);
  import vic_pkg::*;
  localparam int CW = $clog2(LEN + 1);
  localparam logic [CW-1:0] LAST = CW'(LEN - 1);
  logic [CW-1:0] count;
  wire differs = din != dout;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
      dout <= 1'b0;
    end else if (!differs) begin
      count <= '0;
    end else if (count == LAST) begin
      count <= '0;
      dout <= din;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule // vic_noise_filter

// >>> verilog/vic_save_area.sv
// Purpose: single-copy context save area for interrupt entry
// Assumes: save is a one-cycle pulse
// Notes: no stacking; nested entry loses the outer context
module vic_save_area (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic save,
  input wire logic [7:0] accumulator_in,
  input wire logic [7:0] processor_status_in,
  input wire logic [7:0] bank_select_in,
  output logic [7:0] accumulator_out,
  output logic [7:0] processor_status_out,
  output logic [7:0] bank_select_out
);
  import vic_pkg::*;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      accumulator_out <= 8'h00;
      processor_status_out <= 8'h00;
      bank_select_out <= 8'h00;
    end else if (save) begin
      accumulator_out <= accumulator_in;
      processor_status_out <= processor_status_in;
      bank_select_out <= bank_select_in;
    end
  end
endmodule // vic_save_area

// >>> dv/vic_core_model.sv
// Purpose: core-side partner that accepts interrupt requests
// Assumes: bench sets the accept delay per transfer
// Notes: one accept per request, never a second one back to back
module vic_core_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic int_request,
  input wire logic [3:0] delay,
  output logic int_ack
);
  logic [3:0] cnt;

  // ack is a single pulse; the request drops before it could be seen again
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 4'h0;
      int_ack <= 1'b0;
    end else begin
      int_ack <= 1'b0;
      cnt <= 4'h0;
      if (int_request && !int_ack) begin
        if (cnt >= delay) begin
          int_ack <= 1'b1;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule // vic_core_model

// >>> dv/vic_controller_assertions.sv
// Purpose: port-level checks of the interrupt controller
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to every controller instance
module vic_controller_assertions (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic int_ack,
  input wire logic int_request,
  input wire logic [vic_pkg::VEC_W-1:0] int_vector,
  input wire logic enable_interrupts_instr,
  input wire logic disable_interrupts_instr,
  input wire logic sleep_instr,
  input wire logic return_from_interrupt_instr,
  input wire logic wake_up,
  input wire logic asleep,
  input wire logic restore_valid,
  input wire logic [7:0] accumulator_in,
  input wire logic [7:0] accumulator_out,
  input wire logic [7:0] processor_status_in,
  input wire logic [7:0] processor_status_out,
  input wire logic [7:0] bank_select_in,
  input wire logic [7:0] bank_select_out
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_accept;
    int_request && int_ack;
  endsequence

  sequence s_off;
    disable_interrupts_instr && !enable_interrupts_instr ##1 1'b1;
  endsequence

  a_wb_ack_next:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus ack late");
  a_vector_legal:
    assert property (int_request |-> int_vector inside {10'h003, 10'h006, 10'h009,
      10'h00c, 10'h00f, 10'h012, 10'h015, 10'h018, 10'h01b, 10'h01e})
    else $error("vector not in table");
  a_accept_drop:
    assert property (s_accept |=> !int_request)
    else $error("request held after accept");
  a_ctx_save:
    assert property (s_accept |=> accumulator_out == $past(accumulator_in)
      && processor_status_out == $past(processor_status_in)
      && bank_select_out == $past(bank_select_in))
    else $error("context not saved");
  a_ctx_hold:
    assert property (!(int_request && int_ack) |=> $stable(accumulator_out)
      && $stable(processor_status_out) && $stable(bank_select_out))
    else $error("saved context moved");
  a_restore_cause:
    assert property (restore_valid |-> $past(return_from_interrupt_instr))
    else $error("restore without return");
  a_sleep_enter:
    assert property (sleep_instr |=> asleep)
    else $error("sleep not entered");
  a_wake_exit:
    assert property (wake_up |-> !asleep && $past(asleep))
    else $error("wake while awake");
  a_ge_off:
    assert property (s_off |=> !int_request)
    else $error("request with interrupts off");
endmodule // vic_controller_assertions

bind vic_controller vic_controller_assertions u_chk (
  .clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .int_ack, .int_request, .int_vector,
  .enable_interrupts_instr, .disable_interrupts_instr, .sleep_instr,
  .return_from_interrupt_instr, .wake_up, .asleep, .restore_valid,
  .accumulator_in, .accumulator_out, .processor_status_in, .processor_status_out,
  .bank_select_in, .bank_select_out
);

// >>> dv/vic_controller_bench.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: core model accepts requests, bench plays software
// Notes: a read just after an edge sees the cycle before that edge
module vic_controller_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic ext_pin = 1'b0;
  logic [7:0] p5 = 8'hff;
  logic p5_rd = 1'b0;
  logic [7:0] ev = 8'h00;
  logic [3:0] ins = 4'h0;
  logic [3:0] dly = 4'h0;
  logic [23:0] ctx = 24'h0;
  logic [23:0] ctx_out;
  logic int_ack, int_request, wake_up, asleep, restore_valid;
  logic [vic_pkg::VEC_W-1:0] int_vector;
  wire [2:0] hs = {wake_up, int_ack, int_request};
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;

  // ev bits in priority order: main, conv, cmp, high, low, A, B, C
  vic_controller u_dut (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .ext_int_pin(ext_pin), .port5_pins(p5), .port5_read(p5_rd),
    .main_timer_ovf(ev[0]), .conversion_done(ev[1]), .comparator_change(ev[2]),
    .high_pulse_underflow(ev[3]), .low_pulse_underflow(ev[4]), .timer_a_ovf(ev[5]),
    .timer_b_ovf(ev[6]), .timer_c_ovf(ev[7]), .enable_interrupts_instr(ins[0]),
    .disable_interrupts_instr(ins[1]), .return_from_interrupt_instr(ins[2]),
    .sleep_instr(ins[3]), .int_ack(int_ack), .accumulator_in(ctx[23:16]),
    .processor_status_in(ctx[15:8]), .bank_select_in(ctx[7:0]),
    .int_request(int_request), .int_vector(int_vector), .wake_up(wake_up),
    .asleep(asleep), .restore_valid(restore_valid), .accumulator_out(ctx_out[23:16]),
    .processor_status_out(ctx_out[15:8]), .bank_select_out(ctx_out[7:0]));
  vic_core_model u_core (.clk(clk), .arst_n(arst_n), .int_request(int_request),
    .delay(dly), .int_ack(int_ack));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // request held until ack is sampled, then released for one cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat[7:0];
    chk("bus ack", 32'(n < 50), 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(nm, q, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic op(input logic [3:0] k);
    ins <= k;
    @(posedge clk);
    ins <= 4'h0;
  endtask

  task automatic wait_hi(input int w);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hs[w] !== 1'b1 && n < 100);
    chk("wait", 32'(n < 100), 32'h1);
  endtask

  task automatic t_reset;
    wr(8'h40, 8'hff);
    rdc("sec reset", 8'h38, 8'h00);
    rdc("pri reset", 8'h3c, 8'h00);
    rdc("unmapped", 8'hfc, 8'h00);
  endtask

  task automatic t_flags;
    wr(8'h40, 8'h00);
    ev <= 8'hff;
    @(posedge clk);
    ev <= 8'h00;
    rdc("pri masked", 8'h3c, 8'h00);
    op(4'h1);
    repeat (4) @(posedge clk);
    chk("req masked", int_request, 1'b0);
    rdc("core state on", 8'h4c, 8'h01);
    op(4'h2);
    wr(8'h40, 8'hff);
    rdc("pri flags", 8'h3c, 8'hf9);
    rdc("sec flags", 8'h38, 8'h30);
    wr(8'h44, 8'hff);
    chk("req ge off", int_request, 1'b0);
  endtask

  task automatic t_vectors;
    logic [7:0] p, s;
    int pb [8] = '{0, 5, 4, 6, 7, 3, 4, 5};
    p = 8'hf9;
    s = 8'h30;
    op(4'h1);
    for (int i = 0; i < 8; i++) begin
      ctx <= 24'h102030 + 24'(24'h010101 * i);
      dly <= 4'(i);
      wait_hi(0);
      chk("vector", int_vector, 10'h009 + 10'(3 * i));
      wait_hi(1);
      @(posedge clk);
      chk("context", ctx_out, 24'h102030 + 24'(24'h010101 * i));
      if (i == 1 || i == 2) begin
        s[6 - i] = 1'b0;
        wr(8'h38, s);
      end else begin
        p[pb[i]] = 1'b0;
        wr(8'h3c, p);
      end
      chk("req in service", int_request, 1'b0);
      op(4'h4);
      @(posedge clk);
      chk("restore", restore_valid, 1'b1);
    end
  endtask

  task automatic t_ext;
    wr(8'h40, 8'h04);
    ext_pin <= 1'b1;
    repeat (7) @(posedge clk);
    ext_pin <= 1'b0;
    repeat (12) @(posedge clk);
    rdc("short pulse", 8'h3c, 8'h00);
    ext_pin <= 1'b1;
    repeat (12) @(posedge clk);
    ext_pin <= 1'b0;
    repeat (12) @(posedge clk);
    rdc("long pulse", 8'h3c, 8'h04);
    wr(8'h3c, 8'h00);
    wr(8'h48, 8'h02);
    ext_pin <= 1'b1;
    repeat (2) @(posedge clk);
    ext_pin <= 1'b0;
    repeat (6) @(posedge clk);
    rdc("bypass", 8'h3c, 8'h04);
    wr(8'h3c, 8'h00);
    wr(8'h48, 8'h03);
    ext_pin <= 1'b1;
    repeat (6) @(posedge clk);
    rdc("no rise", 8'h3c, 8'h00);
    ext_pin <= 1'b0;
    repeat (6) @(posedge clk);
    rdc("fall", 8'h3c, 8'h04);
    op(4'h1);
    wait_hi(0);
    chk("ext vector", int_vector, 10'h003);
    wait_hi(1);
    wr(8'h3c, 8'h00);
    op(4'h4);
  endtask

  task automatic t_sleep;
    wr(8'h40, 8'h02);
    op(4'h2);
    p5_rd <= 1'b1;
    @(posedge clk);
    p5_rd <= 1'b0;
    op(4'h8);
    @(posedge clk);
    chk("asleep", asleep, 1'b1);
    rdc("core state sleep", 8'h4c, 8'h02);
    p5 <= 8'hfe;
    wait_hi(2);
    repeat (4) @(posedge clk);
    chk("inline", int_request, 1'b0);
    rdc("kept", 8'h3c, 8'h02);
    op(4'h1);
    wait_hi(0);
    chk("pin vector", int_vector, 10'h006);
    wait_hi(1);
    p5_rd <= 1'b1;
    @(posedge clk);
    p5_rd <= 1'b0;
    wr(8'h3c, 8'h00);
    wr(8'h40, 8'h00);
    op(4'h8);
    p5 <= 8'hfc;
    repeat (10) @(posedge clk);
    chk("no wake", asleep, 1'b1);
    // flags set just before reset must not survive it
    ev <= 8'hff;
    @(posedge clk);
    ev <= 8'h00;
    p5 <= 8'hff;
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
  endtask

  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_flags();
    t_vectors();
    t_ext();
    t_sleep();
    finish_test();
  end
endmodule // vic_controller_bench
